//--- shared/ccp_pkg.sv
// constants for the core config and handler priority register bank
// assumes a classic wishbone slave with 32-bit data and byte selects
// What this block does
// [R01] bit 9 picks 4 or 8 byte stack alignment
// [R02] entry records padding in stacked status bit 9
// [R03] return uses stacked bit to undo padding
// [R04] bit 8 lets top handlers ignore data faults
// [R05] bit 8 clear: such faults cause lock-up
// [R06] software sets bit 8 only in safe memory
// [R07] bit 4 set: divide by zero traps
// [R08] bit 4 clear: divide by zero gives zero
// [R09] bit 3 set: unaligned half/word access faults
// [R10] unaligned multiple or doubleword always faults
// [R11] bit 1 allows unprivileged software trigger access
// [R12] bit 0 clear: thread only when none active
// [R13] bit 0 set: thread from any level
// [R14] each system priority is 8 bits, 0..255
// [R15] priority registers accept byte and word access
// [R16] first register: usage, bus, memmgmt priorities
// [R17] second register: supervisor call in top byte
// [R18] third register: tick top, pendable service next
// [R19] unimplemented low priority bits read zero
// [R20] reserved bits read zero, writes ignored
package ccp_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses in the block)
  // ---------------------------------------------------------------
  localparam logic [3:0] CCP_OFS_CTRL = 4'h0;
  localparam logic [3:0] CCP_OFS_PRI1 = 4'h4;
  localparam logic [3:0] CCP_OFS_PRI2 = 4'h8;
  localparam logic [3:0] CCP_OFS_PRI3 = 4'hc;
  // ---------------------------------------------------------------
  // control fields and reset value
  // ---------------------------------------------------------------
  localparam int CCP_BIT_THRD   = 0;
  localparam int CCP_BIT_USTIR  = 1;
  localparam int CCP_BIT_UNAL   = 3;
  localparam int CCP_BIT_DIV0   = 4;
  localparam int CCP_BIT_BFIGN  = 8;
  localparam int CCP_BIT_STKAL  = 9;
  localparam int CCP_PSR_ALIGN  = 9;
  localparam logic [31:0] CCP_CTRL_MASK  = 32'h0000_031b;
  localparam logic [31:0] CCP_CTRL_RESET = 32'h0000_0000;
  // priority field masks per register word
  localparam logic [31:0] CCP_PRI1_MASK  = 32'h00ff_ffff;
  localparam logic [31:0] CCP_PRI2_MASK  = 32'hff00_0000;
  localparam logic [31:0] CCP_PRI3_MASK  = 32'hffff_0000;
  localparam logic [31:0] CCP_PRI_RESET  = 32'h0000_0000;
endpackage : ccp_pkg

//--- src/ccp_regs.sv
// core config control and system handler priority registers
// assumes the core exception, load/store and divide units consume
// the decisions below in the same clock; one clock, async reset
`timescale 1ns/1ps
module ccp_regs
  import ccp_pkg::*;
#(
  parameter int PRI_BITS = 8
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // configuration seen by the core
  output logic             stack_double_align,
  output logic             high_pri_bus_fault_ignore,
  output logic             zero_divisor_trap_en,
  output logic             misaligned_trap_en,
  output logic             unpriv_sw_trigger_en,
  output logic             any_level_thread_entry,
  output logic      [7:0]  memmgmt_fault_prio,
  output logic      [7:0]  bus_fault_b_prio,
  output logic      [7:0]  usage_fault_a_prio,
  output logic      [7:0]  supervisor_call_prio,
  output logic      [7:0]  pendable_service_prio,
  output logic      [7:0]  system_tick_prio,
  // exception entry and return
  input  wire logic        exc_entry,
  input  wire logic [31:0] entry_sp,
  output logic      [31:0] entry_sp_aligned,
  output logic             stacked_psr_align,
  input  wire logic        exception_return_code,
  input  wire logic [31:0] return_sp,
  input  wire logic        stacked_psr_bit,
  output logic      [31:0] return_sp_restored,
  // data bus fault in priority -1/-2 handler
  input  wire logic        data_bus_fault,
  input  wire logic        in_top_pri_handler,
  output logic             bus_fault_ignored,
  output logic             lockup,
  // divide by zero
  input  wire logic        div_exec,
  input  wire logic        div_by_zero,
  output logic             div_trap,
  output logic             div_force_zero,
  // memory access alignment
  input  wire logic        mem_access,
  input  wire logic        mem_unaligned,
  input  wire logic        mem_half_or_word,
  input  wire logic        mem_multi_or_dword,
  output logic             usage_fault_align,
  // software trigger register access
  input  wire logic        sw_trig_access,
  input  wire logic        privileged,
  output logic             sw_trig_allow,
  // thread mode return
  input  wire logic        return_to_thread,
  input  wire logic        other_exc_active,
  output logic             thread_return_ok
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q,   ctrl_d;
  logic [31:0] pri1_q,   pri1_d;
  logic [31:0] pri2_q,   pri2_d;
  logic [31:0] pri3_q,   pri3_d;
  logic        ack_q;
  logic        err_q;
  logic [31:0] rdata_q;
  logic        lockup_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // [R19] unimplemented priority bits
  // top PRI_BITS of each byte are kept and the low-order rest tie low,
  // so a narrower build still orders priorities the same way
  localparam logic [7:0] PRI_BYTE = 8'(8'hff << (8 - PRI_BITS));
  wire [31:0] pri_impl  = {4{PRI_BYTE}};
  wire        req       = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  wire        hit_ctrl  = (wb_adr_i == CCP_OFS_CTRL);
  wire        hit_pri1  = (wb_adr_i == CCP_OFS_PRI1);
  wire        hit_pri2  = (wb_adr_i == CCP_OFS_PRI2);
  wire        hit_pri3  = (wb_adr_i == CCP_OFS_PRI3);
  wire        hit_any   = hit_ctrl | hit_pri1 | hit_pri2 | hit_pri3;
  wire        wr        = req && wb_we_i && hit_any;
  wire [31:0] bmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // [R15] byte lane merge
  wire [31:0] wmask     = bmask & {32{wr}};
  wire [31:0] merged_c  = (ctrl_q & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] merged_1  = (pri1_q & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] merged_2  = (pri2_q & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] merged_3  = (pri3_q & ~wmask) | (wb_dat_i & wmask);

  // [R20] reserved bits kept zero
  assign ctrl_d = hit_ctrl ? (merged_c & CCP_CTRL_MASK) : ctrl_q;
  // [R16] first priority word layout
  assign pri1_d = hit_pri1 ? (merged_1 & CCP_PRI1_MASK & pri_impl) : pri1_q;
  // [R17] second priority word layout
  assign pri2_d = hit_pri2 ? (merged_2 & CCP_PRI2_MASK & pri_impl) : pri2_q;
  // [R18] third priority word layout
  assign pri3_d = hit_pri3 ? (merged_3 & CCP_PRI3_MASK & pri_impl) : pri3_q;

  // read selection, unmapped reads zero
  wire [31:0] rsel = hit_ctrl ? ctrl_q :
                     hit_pri1 ? pri1_q :
                     hit_pri2 ? pri2_q :
                     hit_pri3 ? pri3_q : 32'h0000_0000;

  // registers update on the single accepted cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CCP_CTRL_RESET;
      pri1_q <= CCP_PRI_RESET;
      pri2_q <= CCP_PRI_RESET;
      pri3_q <= CCP_PRI_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      pri1_q <= pri1_d;
      pri2_q <= pri2_d;
      pri3_q <= pri3_d;
    end
  end

  // ack one cycle after request; unmapped answered with err
  // the cycle in which an answer is out is never taken again, so a master
  // that keeps stb high through the answer cycle does not write twice
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= req && hit_any;
      err_q   <= req && !hit_any;
      rdata_q <= (req && !wb_we_i) ? rsel : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;

  // ---------------------------------------------------------------
  // fields to the core
  // ---------------------------------------------------------------
  // [R14] eight bit priority fields
  assign memmgmt_fault_prio        = pri1_q[7:0];
  assign bus_fault_b_prio             = pri1_q[15:8];
  assign usage_fault_a_prio           = pri1_q[23:16];
  assign supervisor_call_prio      = pri2_q[31:24];
  assign pendable_service_prio     = pri3_q[23:16];
  assign system_tick_prio          = pri3_q[31:24];
  assign stack_double_align        = ctrl_q[CCP_BIT_STKAL];
  assign high_pri_bus_fault_ignore = ctrl_q[CCP_BIT_BFIGN];
  assign zero_divisor_trap_en      = ctrl_q[CCP_BIT_DIV0];
  assign misaligned_trap_en        = ctrl_q[CCP_BIT_UNAL];
  assign unpriv_sw_trigger_en      = ctrl_q[CCP_BIT_USTIR];
  assign any_level_thread_entry    = ctrl_q[CCP_BIT_THRD];

  // ---------------------------------------------------------------
  // stack alignment on entry and return
  // ---------------------------------------------------------------
  // [R01] pad to 8 bytes when enabled
  wire pad_need = stack_double_align && entry_sp[2];
  assign entry_sp_aligned  = pad_need ? {entry_sp[31:3], 3'b000} : entry_sp;
  // [R02] stacked status records padding
  assign stacked_psr_align = exc_entry && pad_need;
  // [R03] undo padding on return
  assign return_sp_restored = (exception_return_code && stacked_psr_bit) ?
                              (return_sp | 32'h0000_0004) : return_sp;

  // ---------------------------------------------------------------
  // fault decisions
  // ---------------------------------------------------------------
  wire top_fault = data_bus_fault && in_top_pri_handler;
  // [R04] ignore in top handlers
  assign bus_fault_ignored = top_fault && high_pri_bus_fault_ignore;

  // [R05] lock-up holds until reset
  // sticky on purpose: the core has no way back from lock-up short of reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lockup_q <= 1'b0;
    end else if (top_fault && !high_pri_bus_fault_ignore) begin
      lockup_q <= 1'b1;
    end
  end
  assign lockup = lockup_q;

  // [R07] trap divide by zero
  assign div_trap       = div_exec && div_by_zero && zero_divisor_trap_en;
  // [R08] zero quotient otherwise
  assign div_force_zero = div_exec && div_by_zero && !zero_divisor_trap_en;

  // [R09] [R10] alignment faults
  assign usage_fault_align = mem_access && mem_unaligned &&
                             (mem_multi_or_dword ||
                              (mem_half_or_word && misaligned_trap_en));

  // [R11] unprivileged trigger gate
  assign sw_trig_allow = sw_trig_access && (privileged || unpriv_sw_trigger_en);

  // [R12] [R13] thread return check
  assign thread_return_ok = return_to_thread &&
                            (any_level_thread_entry || !other_exc_active);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_ctrl_reserved: assert property ((ctrl_q & ~CCP_CTRL_MASK) == 32'h0) // [R20]
    else $error("control reserved bit set");
  chk_pri_lowbits: assert property ((pri1_q & ~pri_impl) == 32'h0) // [R19]
    else $error("unimplemented priority bit set");
  chk_pri2_low: assert property (pri2_q[23:0] == 24'h0) // [R17]
    else $error("second priority low bits nonzero");
  chk_pri3_low: assert property (pri3_q[15:0] == 16'h0) // [R18]
    else $error("third priority low bits nonzero");
  chk_byte_write: assert property (wr && hit_pri1 && wb_sel_i == 4'h1 |=> // [R15]
    pri1_q[23:8] == $past(pri1_q[23:8]))
    else $error("byte write touched other lanes");
  chk_ack_timing: assert property (req && hit_any |=> wb_ack_o ##1 !wb_ack_o) // [R15]
    else $error("ack not one cycle");
  chk_lockup_set: assert property (top_fault && !high_pri_bus_fault_ignore |=> lockup) // [R05]
    else $error("no lockup on top fault");
  chk_div_trap: assert property (div_trap |-> !div_force_zero && ctrl_q[4]) // [R07]
    else $error("divide trap mismatch");
  chk_multi_fault: assert property (mem_access && mem_unaligned && mem_multi_or_dword // [R10]
    |-> usage_fault_align)
    else $error("unaligned multiple not faulted");
  chk_thread_ret: assert property (return_to_thread && other_exc_active && !ctrl_q[0] // [R12]
    |-> !thread_return_ok)
    else $error("thread return allowed while active");
  chk_align_pad: assert property (stacked_psr_align |-> entry_sp_aligned[2:0] == 3'b000) // [R01]
    else $error("padded stack not 8 aligned");

  // ---------------------------------------------------------------
  // further checks on bus answers and core decisions
  // ---------------------------------------------------------------
  // [R16] reserved top byte
  chk_pri1_top: assert property (pri1_q[31:24] == 8'h00) // [R16]
    else $error("first priority top byte nonzero");

  // [R20] unmapped answer
  chk_unmapped_err: assert property (req && !hit_any |=> wb_err_o ##1 !wb_err_o) // [R20]
    else $error("unmapped access not answered by err");

  // [R20] one answer only
  chk_ack_err_excl: assert property (!(wb_ack_o && wb_err_o)) // [R20]
    else $error("ack and err together");

  // [R20] idle read data
  chk_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) // [R20]
    else $error("read data outside ack");

  // [R20] control read back
  chk_read_ctrl: assert property (req && !wb_we_i && hit_ctrl |=> // [R20]
    wb_dat_o == $past(ctrl_q))
    else $error("control read data wrong");

  // [R20] control write masked
  chk_ctrl_write: assert property (wr && hit_ctrl && wb_sel_i == 4'hf |=> // [R20]
    ctrl_q == ($past(wb_dat_i) & CCP_CTRL_MASK))
    else $error("control write not masked");

  // [R05] lock-up sticky
  chk_lockup_hold: assert property (lockup |=> lockup) // [R05]
    else $error("lockup dropped before reset");

  // [R04] ignored fault
  chk_bf_ignore: assert property (top_fault && high_pri_bus_fault_ignore // [R04]
    |-> bus_fault_ignored)
    else $error("top handler fault not ignored");

  // [R08] zero quotient
  chk_div_zero: assert property (div_exec && div_by_zero && !zero_divisor_trap_en // [R08]
    |-> div_force_zero && !div_trap)
    else $error("untrapped divide by zero wrong");

  // [R09] trap on unaligned
  chk_align_trap: assert property (mem_access && mem_unaligned && mem_half_or_word // [R09]
    && misaligned_trap_en |-> usage_fault_align)
    else $error("unaligned access not trapped");

  // [R09] no trap when off
  chk_align_free: assert property (mem_access && mem_unaligned && !mem_multi_or_dword // [R09]
    && !misaligned_trap_en |-> !usage_fault_align)
    else $error("unaligned access trapped while off");

  // [R11] unprivileged denied
  chk_trig_gate: assert property (sw_trig_access && !privileged // [R11]
    && !unpriv_sw_trigger_en |-> !sw_trig_allow)
    else $error("unprivileged trigger access allowed");

  // [R13] any level entry
  chk_thread_any: assert property (return_to_thread && any_level_thread_entry // [R13]
    |-> thread_return_ok)
    else $error("thread return refused at any level");

  // [R03] padding undone
  chk_restore: assert property (exception_return_code && stacked_psr_bit // [R03]
    |-> return_sp_restored[2])
    else $error("padding not undone on return");

  // [R02] no pad when off
  chk_no_pad: assert property (exc_entry && !stack_double_align // [R02]
    |-> !stacked_psr_align && entry_sp_aligned == entry_sp)
    else $error("stack padded while alignment off");

  // main scenarios seen by the bench
  cov_unmapped: cover property (wb_err_o);
  cov_lockup:   cover property (top_fault ##1 lockup);
  cov_byte_wr:  cover property (wr && wb_sel_i == 4'h8);
  cov_div_zero: cover property (div_force_zero);
  cov_pad:      cover property (stacked_psr_align);
endmodule // ccp_regs

//--- tb/ccp_regs_tb_top.sv
// bench for the core config and handler priority register bank
// assumes a one-cycle wishbone answer and combinational core decisions
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module ccp_regs_tb_top;
  import ccp_pkg::*;
  logic        mclk, rst_n, cyc, stb, we, ack, err, exp_lock;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, esp, rsp, sp_al, sp_rs, lfsr_q;
  logic        sda, bfi, dze, mte, ust, ale, sta, bfg, lock, dtr, dfz, ufa, swo, tok;
  logic        ent, ret, spb, dbf, top, dex, dbz, mac, mun, mhw, mmd, swa, prv, rtt, oea;
  logic [7:0]  p_mm, p_bf, p_uf, p_sv, p_ps, p_st;
  logic [31:0] regs [4];
  logic [33:0] notes [$];
  int          miscompares, total_checks;
  ccp_regs #(.PRI_BITS(8)) ccp_regs_i (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .stack_double_align(sda),
    .high_pri_bus_fault_ignore(bfi), .zero_divisor_trap_en(dze), .misaligned_trap_en(mte),
    .unpriv_sw_trigger_en(ust), .any_level_thread_entry(ale), .memmgmt_fault_prio(p_mm),
    .bus_fault_b_prio(p_bf), .usage_fault_a_prio(p_uf), .supervisor_call_prio(p_sv),
    .pendable_service_prio(p_ps), .system_tick_prio(p_st), .exc_entry(ent),
    .entry_sp(esp), .entry_sp_aligned(sp_al), .stacked_psr_align(sta), .exception_return_code(ret),
    .return_sp(rsp), .stacked_psr_bit(spb), .return_sp_restored(sp_rs),
    .data_bus_fault(dbf), .in_top_pri_handler(top), .bus_fault_ignored(bfg), .lockup(lock),
    .div_exec(dex), .div_by_zero(dbz), .div_trap(dtr), .div_force_zero(dfz),
    .mem_access(mac), .mem_unaligned(mun), .mem_half_or_word(mhw),
    .mem_multi_or_dword(mmd), .usage_fault_align(ufa), .sw_trig_access(swa),
    .privileged(prv), .sw_trig_allow(swo), .return_to_thread(rtt),
    .other_exc_active(oea), .thread_return_ok(tok));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic void rnd(output logic [31:0] v);
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    v = lfsr_q;
  endfunction
  function automatic logic [31:0] msk(logic [1:0] k);
    return (k == 2'd0) ? CCP_CTRL_MASK : (k == 2'd1) ? CCP_PRI1_MASK :
           (k == 2'd2) ? CCP_PRI2_MASK : CCP_PRI3_MASK;
  endfunction
  task automatic close_out();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one classic cycle; the note is queued before the request goes out
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    int  n;
    logic hit;
    hit = (a[1:0] == 2'b00);
    if (w && hit) for (int i = 0; i < 4; i++) if (s[i]) regs[a[3:2]][8*i +: 8] = d[8*i +: 8];
    regs[a[3:2]] &= msk(a[3:2]);
    notes.push_back({!w && hit, !hit, regs[a[3:2]]});
    @(posedge mclk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
    dbf <= 1'b0; // keeps the lockup model free of config changes mid-cycle
    n = 0;
    do begin @(posedge mclk); n++; end while (!(ack | err) && n < 20);
    {cyc, stb} <= 2'b00;
    if (!(ack | err)) begin miscompares++; close_out(); end
  endtask
  // random core-side stimulus, decisions checked once settled
  task automatic core();
    logic [31:0] v, u, c;
    logic        pad;
    @(posedge mclk);
    rnd(v);
    rnd(u);
    {ent, ret, spb, dbf, top, dex, dbz, mac, mun, mhw, mmd, swa, prv, rtt, oea} <= v[14:0];
    esp <= u & 32'hffff_fffc;
    rsp <= ~u & 32'hffff_fff8;
    @(negedge mclk);
    c = regs[0];
    pad = c[9] & esp[2];
    `CHK(sp_al, pad ? (esp & 32'hffff_fff8) : esp)
    `CHK(sta, ent & pad)
    `CHK(sp_rs, (ret & spb) ? (rsp | 32'h0000_0004) : rsp)
    `CHK(bfg, dbf & top & c[8])
    `CHK(lock, exp_lock)
    `CHK({dtr, dfz}, {dex & dbz & c[4], dex & dbz & ~c[4]})
    `CHK(ufa, mac & mun & (mmd | (mhw & c[3])))
    `CHK(swo, swa & (prv | c[1]))
    `CHK(tok, rtt & (~oea | c[0]))
    exp_lock = exp_lock | (dbf & top & ~c[8]);
  endtask
  // ---------------------------------------------------------------
  // clock, answer monitor and main sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    logic [33:0] nt;
    if (ack | err) begin
      nt = notes.pop_front();
      `CHK(err, nt[32])
      if (nt[33]) `CHK(rdat, nt[31:0])
    end
  end
  initial begin
    logic [31:0] v;
    lfsr_q = 32'h33f54802;
    {rst_n, cyc, stb, we, adr, sel, wdat, esp, rsp, exp_lock} = '0;
    {ent, ret, spb, dbf, top, dex, dbz, mac, mun, mhw, mmd, swa, prv, rtt, oea} = '0;
    for (int k = 0; k < 4; k++) regs[k] = (k == 0) ? CCP_CTRL_RESET : CCP_PRI_RESET;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) bus(1'b0, 4'(4 * k), 4'hf, 32'h0);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 4'(4 * k), 4'hf, 32'hffff_ffff);
      bus(1'b0, 4'(4 * k), 4'hf, 32'h0);
    end
    // single-lane writes must leave the other fields alone
    repeat (24) begin
      rnd(v);
      bus(1'b1, {v[3:2], 2'b00}, 4'h1 << v[5:4], v);
      bus(1'b0, {v[3:2], 2'b00}, 4'hf, 32'h0);
    end
    bus(1'b1, 4'h6, 4'hf, 32'hffff_ffff);
    bus(1'b0, 4'h6, 4'hf, 32'h0);
    repeat (40) begin
      rnd(v);
      // software side: bit 8 set freely, fault region assumed safe
      bus(1'b1, CCP_OFS_CTRL, 4'hf, v);
      rnd(v);
      bus(1'b1, {v[3:2], 2'b00}, 4'hf, v);
      @(negedge mclk);
      `CHK({sda, bfi, dze, mte, ust, ale}, {regs[0][9:8], regs[0][4:3], regs[0][1:0]})
      `CHK({p_uf, p_bf, p_mm, p_sv}, {regs[1][23:0], regs[2][31:24]})
      `CHK({p_st, p_ps}, regs[3][31:16])
      repeat (4) core();
    end
    close_out();
  end
endmodule // ccp_regs_tb_top
